//--- synth_defines.svh
`ifndef SYNTH_DEFINES_SVH
`define SYNTH_DEFINES_SVH

// ------------------------------------------------------------------
// Select code, stream layout and register map.
// ------------------------------------------------------------------
`define SEL_CODE 3'h2
`define REF_BITS 14
`define MAIN_BITS 10
`define SWAL_BITS 7
`define WORD_BITS 32
`define CTRL_POS 0
`define SWAL_LSB 1
`define MAIN_LSB 8
`define REF_LSB 18
`define REF_DEFAULT 14'h0800
`define MAIN_DEFAULT 10'h001
`define SWAL_DEFAULT 7'h00
`define MODULUS 8'h80
`define ADDR_CMD 4'h0
`define ADDR_STAT 4'h1
`define ADDR_IRQ_STAT 4'h2
`define ADDR_IRQ_CLR 4'h3
`define ADDR_IRQ_EN 4'h4
`define ADDR_MODE 4'h5
`define CLK_DIV 8'h04
`define IRQ_DONE 0
`define IRQ_LOCK 1
`define IRQ_LOSS 2

`endif

//--- synth_pkg.sv
`default_nettype none
package synth_pkg;
    typedef enum logic [1:0] {
        MODE_NARROW,
        MODE_WIDE,
        MODE_TUNE
    } loop_mode_t;
    typedef enum {
        SEND_IDLE,
        SEND_LOW,
        SEND_HIGH,
        SEND_LATCH
    } send_state_t;
endpackage
`default_nettype wire

//--- synth_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface synth_link_if;
    logic module_select_bit0;
    logic module_select_bit1;
    logic module_select_bit2;
    logic ser_clk;
    logic ser_data;
    logic ser_latch;
    logic lock_flag;
    modport controller (
        output module_select_bit0, module_select_bit1, module_select_bit2,
        output ser_clk, ser_data, ser_latch,
        input lock_flag
    );
    modport synth (
        input module_select_bit0, module_select_bit1, module_select_bit2,
        input ser_clk, ser_data, ser_latch,
        output lock_flag
    );
endinterface
`default_nettype wire

//--- synth_module.sv
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "synth_defines.svh"

// Functional notes
// - Pass serial lines only for select 010.
// - Shift data on rising serial clock.
// - Latch high copies shift word to dividers.
// - Send reference, main, swallow, each MSB first.
// - Latch only when final control bit one.
// - Divide reference input by reference value.
// - Dual-modulus main and swallow divide feedback.
// - Lock high while divided signals in phase.
// - Lock flag follows internal lock indicator.
// - Fault lamp on while lock lost.
// - Drive three loop-filter switch controls.
// - Controller checks lock flag after each load.
module synth_module #(
    parameter int REF_W = `REF_BITS,
    parameter int MAIN_W = `MAIN_BITS,
    parameter int SWAL_W = `SWAL_BITS
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Link to the controller.
    synth_link_if.synth link,
    // Analog-side signals.
    input wire logic reference_input_in,
    input wire logic prescaled_feedback_in,
    input wire logic [1:0] loop_mode_in,
    output logic modulus_ctrl_out,
    output logic divided_reference_out,
    output logic divided_feedback_out,
    output logic phase_error_out,
    output logic fault_lamp_out,
    output logic open_loop_out,
    output logic enable_not_out,
    output logic tune_ctrl_out
);
    initial begin
        if (REF_W + MAIN_W + SWAL_W + 1 != `WORD_BITS) begin
            $error("Divider widths must fill the stream word.");
        end
    end

    // ------------------------------------------------------------------
    // Input synchronisers and serial decode.
    // ------------------------------------------------------------------
    logic [2:0] clk_sync;
    logic [2:0] lat_sync;
    logic [2:0] ref_sync;
    logic [2:0] fb_sync;
    logic [2:0] dat_sync;
    logic selected;
    logic [`WORD_BITS-1:0] shift_word;
    logic [REF_W-1:0] ref_div;
    logic [MAIN_W-1:0] main_div;
    logic [SWAL_W-1:0] swal_div;
    logic [REF_W-1:0] ref_cnt;
    logic [MAIN_W-1:0] main_cnt;
    logic [SWAL_W-1:0] swal_cnt;
    logic ref_pulse;
    logic fb_pulse;
    logic lock_indicator;

    // Three-stage synchronisers; stage two and three decide edges.
    always_ff @(posedge mclk_in) begin
        clk_sync <= {clk_sync[1:0], link.ser_clk};
        lat_sync <= {lat_sync[1:0], link.ser_latch};
        ref_sync <= {ref_sync[1:0], reference_input_in};
        fb_sync <= {fb_sync[1:0], prescaled_feedback_in};
        dat_sync <= {dat_sync[1:0], link.ser_data};
    end

    // Gate serial lines by the module select code.
    assign selected = ({link.module_select_bit2, link.module_select_bit1,
                        link.module_select_bit0} == `SEL_CODE);

    // Shift register holds the latest 32 bits, oldest at the top.
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            shift_word <= '0;
        end else if (selected && clk_sync[1] && !clk_sync[2]) begin
            shift_word <= {shift_word[`WORD_BITS-2:0], dat_sync[1]};
        end
    end

    // Divider latches load on latch high when the control bit is set.
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            ref_div <= REF_W'(`REF_DEFAULT);
            main_div <= MAIN_W'(`MAIN_DEFAULT);
            swal_div <= SWAL_W'(`SWAL_DEFAULT);
        end else if (selected && lat_sync[1] && lat_sync[2]
                     && shift_word[`CTRL_POS]) begin
            ref_div <= shift_word[`REF_LSB +: REF_W];
            main_div <= shift_word[`MAIN_LSB +: MAIN_W];
            swal_div <= shift_word[`SWAL_LSB +: SWAL_W];
        end
    end

    // ------------------------------------------------------------------
    // Dividers and phase comparison.
    // ------------------------------------------------------------------
    // Reference divider counts rising reference edges.
    always_ff @(posedge mclk_in) begin
        ref_pulse <= 1'b0;
        if (!resetn_in) begin
            ref_cnt <= '0;
        end else if (ref_sync[1] && !ref_sync[2]) begin
            if (ref_cnt + REF_W'(1) >= ref_div) begin
                ref_cnt <= '0;
                ref_pulse <= 1'b1;
            end else begin
                ref_cnt <= ref_cnt + REF_W'(1);
            end
        end
    end

    // Swallow count runs first with high modulus, then main finishes.
    always_ff @(posedge mclk_in) begin
        fb_pulse <= 1'b0;
        if (!resetn_in) begin
            main_cnt <= '0;
            swal_cnt <= '0;
        end else if (fb_sync[1] && !fb_sync[2]) begin
            if (main_cnt + MAIN_W'(1) >= main_div) begin
                main_cnt <= '0;
                swal_cnt <= '0;
                fb_pulse <= 1'b1;
            end else begin
                main_cnt <= main_cnt + MAIN_W'(1);
                if (swal_cnt < swal_div) begin
                    swal_cnt <= swal_cnt + SWAL_W'(1);
                end
            end
        end
    end

    // Phase error is set by reference pulse and cleared by feedback.
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            modulus_ctrl_out <= 1'b0;
            divided_reference_out <= 1'b0;
            divided_feedback_out <= 1'b0;
            phase_error_out <= 1'b0;
            lock_indicator <= 1'b0;
        end else begin
            modulus_ctrl_out <= (swal_cnt < swal_div);
            divided_reference_out <= ref_pulse;
            divided_feedback_out <= fb_pulse;
            if (ref_pulse != fb_pulse) begin
                phase_error_out <= ref_pulse;
            end
            if (ref_pulse && fb_pulse) begin
                lock_indicator <= 1'b1;
            end else if (ref_pulse || fb_pulse) begin
                lock_indicator <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fault logic and loop-filter switches.
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            link.lock_flag <= 1'b0;
            fault_lamp_out <= 1'b1;
            open_loop_out <= 1'b0;
            enable_not_out <= 1'b0;
            tune_ctrl_out <= 1'b0;
        end else begin
            link.lock_flag <= lock_indicator;
            fault_lamp_out <= !lock_indicator;
            open_loop_out <= (loop_mode_in == synth_pkg::MODE_TUNE);
            enable_not_out <= (loop_mode_in == synth_pkg::MODE_NARROW);
            tune_ctrl_out <= (loop_mode_in == synth_pkg::MODE_TUNE);
        end
    end
endmodule
`default_nettype wire

//--- synth_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "synth_defines.svh"

module synth_controller (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Software port.
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    // Link to the synthesizer.
    synth_link_if.controller link
);
    // ------------------------------------------------------------------
    // Registers and link state.
    // ------------------------------------------------------------------
    synth_pkg::send_state_t state;
    logic [`WORD_BITS-1:0] tx_word;
    logic [5:0] bit_cnt;
    logic [7:0] div_cnt;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [1:0] mode;
    logic [2:0] flag_sync;
    logic busy;
    logic load_done;

    assign busy = (state != synth_pkg::SEND_IDLE);
    assign irq_out = |(irq_stat & irq_en);

    // Command write starts a stream with the control bit forced high.
    always_ff @(posedge mclk_in) begin
        load_done <= 1'b0;
        if (!resetn_in) begin
            state <= synth_pkg::SEND_IDLE;
            tx_word <= '0;
            bit_cnt <= '0;
            div_cnt <= '0;
            link.ser_clk <= 1'b0;
            link.ser_data <= 1'b0;
            link.ser_latch <= 1'b0;
            {link.module_select_bit2, link.module_select_bit1,
             link.module_select_bit0} <= 3'h0;
        end else begin
            div_cnt <= (div_cnt + 8'h01 >= `CLK_DIV) ? 8'h00 : div_cnt + 8'h01;
            case (state)
                synth_pkg::SEND_IDLE: begin
                    link.ser_latch <= 1'b0;
                    if (wr_in && addr_in == `ADDR_CMD) begin
                        // Reference, main, swallow MSB first, then control bit one.
                        tx_word <= {wdata_in[`WORD_BITS-1:1], 1'b1};
                        bit_cnt <= '0;
                        div_cnt <= '0;
                        state <= synth_pkg::SEND_LOW;
                        {link.module_select_bit2, link.module_select_bit1,
                         link.module_select_bit0} <= `SEL_CODE;
                    end
                end
                synth_pkg::SEND_LOW: begin
                    link.ser_clk <= 1'b0;
                    link.ser_data <= tx_word[`WORD_BITS-1];
                    if (div_cnt == 8'h00) begin
                        state <= synth_pkg::SEND_HIGH;
                    end
                end
                synth_pkg::SEND_HIGH: begin
                    if (div_cnt == 8'h00) begin
                        link.ser_clk <= 1'b1;
                        tx_word <= {tx_word[`WORD_BITS-2:0], 1'b0};
                        bit_cnt <= bit_cnt + 6'h01;
                        state <= (bit_cnt == 6'(`WORD_BITS - 1)) ?
                                 synth_pkg::SEND_LATCH : synth_pkg::SEND_LOW;
                    end
                end
                synth_pkg::SEND_LATCH: begin
                    if (div_cnt == 8'h00) begin
                        link.ser_clk <= 1'b0;
                        link.ser_latch <= 1'b1;
                        if (link.ser_latch) begin
                            link.ser_latch <= 1'b0;
                            load_done <= 1'b1;
                            {link.module_select_bit2, link.module_select_bit1,
                             link.module_select_bit0} <= 3'h0;
                            state <= synth_pkg::SEND_IDLE;
                        end
                    end
                end
                default: state <= synth_pkg::SEND_IDLE;
            endcase
        end
    end

    // Lock flag synchroniser.
    always_ff @(posedge mclk_in) begin
        flag_sync <= {flag_sync[1:0], link.lock_flag};
    end

    // Sticky events: load done, lock gained, lock lost; set wins over clear.
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            irq_stat <= 3'h0;
        end else begin
            irq_stat <= (irq_stat & ~((wr_in && addr_in == `ADDR_IRQ_CLR) ?
                        wdata_in[2:0] : 3'h0))
                        | {flag_sync[2] && !flag_sync[1],
                           flag_sync[1] && !flag_sync[2], load_done};
        end
    end

    // Enable and mode registers.
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            irq_en <= 3'h0;
            mode <= 2'h0;
        end else if (wr_in && addr_in == `ADDR_IRQ_EN) begin
            irq_en <= wdata_in[2:0];
        end else if (wr_in && addr_in == `ADDR_MODE) begin
            mode <= wdata_in[1:0];
        end
    end

    // Read data one cycle after the strobe.
    always_ff @(posedge mclk_in) begin
        if (!resetn_in || !rd_in) begin
            rdata_out <= 32'h0;
        end else begin
            case (addr_in)
                `ADDR_CMD: rdata_out <= tx_word;
                `ADDR_STAT: rdata_out <= {30'h0, flag_sync[2], busy};
                `ADDR_IRQ_STAT: rdata_out <= {29'h0, irq_stat};
                `ADDR_IRQ_EN: rdata_out <= {29'h0, irq_en};
                `ADDR_MODE: rdata_out <= {30'h0, mode};
                default: rdata_out <= 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- synth_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module synth_link_monitor (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Link lines.
    input wire logic module_select_bit0,
    input wire logic module_select_bit1,
    input wire logic module_select_bit2,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_latch,
    input wire logic lock_flag
);
    logic sel;
    logic clk_q;
    logic last_bit;
    logic [5:0] nbits;
    assign sel = {module_select_bit2, module_select_bit1, module_select_bit0} == 3'h2;
    // Counts serial clock rises inside one selected frame.
    always_ff @(posedge mclk_in) begin
        clk_q <= ser_clk;
        if (!resetn_in || !sel) begin
            nbits <= 6'h00;
        end else if (ser_clk && !clk_q) begin
            nbits <= nbits + 6'h01;
        end
    end
    // Keeps the bit that was on the data line at the last clock rise.
    always_ff @(posedge mclk_in) begin
        if (ser_clk && !clk_q) begin
            last_bit <= ser_data;
        end
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // ----
    // Frame checks.
    // ----
    sequence s_frame_start;
        $rose(sel);
    endsequence
    sequence s_latch_soon;
        ##[1:1000] $rose(ser_latch);
    endsequence
    a_select_clock: assert property ($rose(ser_clk) |-> sel)
        else $error("serial clock rose while deselected");
    a_latch_selected: assert property ($rose(ser_latch) |-> sel)
        else $error("latch rose while deselected");
    a_data_setup: assert property ($rose(ser_clk) |-> $stable(ser_data))
        else $error("data moved at the clock rise");
    a_latch_count: assert property ($rose(ser_latch) |-> nbits == 6'h20)
        else $error("latch after a frame not of 32 bits");
    a_ctrl_bit: assert property ($rose(ser_latch) |-> last_bit)
        else $error("final control bit was low");
    a_latch_clk_low: assert property (ser_latch |-> !ser_clk)
        else $error("clock high during latch");
    a_latch_short: assert property ($rose(ser_latch) |-> ##[1:16] !ser_latch)
        else $error("latch pulse too long");
    a_frame_ends: assert property (s_frame_start |-> s_latch_soon)
        else $error("frame did not end in a latch");
endmodule
`default_nettype wire

//--- synth_serial_load_lock_flag_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "synth_defines.svh"
module synth_serial_load_lock_flag_tb;
    logic mclk_in = 1'b0, resetn_in = 1'b0, ref_src = 1'b0, fb_on = 1'b1;
    logic wr_in = 1'b0, rd_in = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0, rdata_out, exp_word = 32'h0, v, cap;
    logic irq_out, fault_lamp_out, open_loop_out, enable_not_out, tune_ctrl_out;
    logic [2:0] trip [3];
    int err_count = 0, n_compared = 0, frames = 0, nbits = 0;
    synth_link_if u_synth_link_if ();
    wire [2:0] sel = {u_synth_link_if.module_select_bit2, u_synth_link_if.module_select_bit1,
        u_synth_link_if.module_select_bit0};
    synth_module u_synth_module (.mclk_in, .resetn_in, .link(u_synth_link_if.synth),
        .reference_input_in(ref_src), .prescaled_feedback_in(ref_src & fb_on),
        .loop_mode_in(mode), .modulus_ctrl_out(), .divided_reference_out(),
        .divided_feedback_out(), .phase_error_out(), .fault_lamp_out, .open_loop_out,
        .enable_not_out, .tune_ctrl_out);
    synth_controller u_synth_controller (.mclk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
        .rd_in, .rdata_out, .irq_out, .link(u_synth_link_if.controller));
    synth_link_monitor u_synth_link_monitor (.mclk_in, .resetn_in,
        .module_select_bit0(u_synth_link_if.module_select_bit0),
        .module_select_bit1(u_synth_link_if.module_select_bit1),
        .module_select_bit2(u_synth_link_if.module_select_bit2),
        .ser_clk(u_synth_link_if.ser_clk), .ser_data(u_synth_link_if.ser_data),
        .ser_latch(u_synth_link_if.ser_latch), .lock_flag(u_synth_link_if.lock_flag));
    // System clock and a 200 ns reference source.
    initial forever #12.5 mclk_in = ~mclk_in;
    initial forever #100 ref_src = ~ref_src;
    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One write cycle, then one idle cycle.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
        @(posedge mclk_in);
    endtask
    // One read cycle; data are taken in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        @(posedge mclk_in);
        d = rdata_out;
    endtask
    // Starts a load, sends a second word while busy, and waits for the end.
    task automatic load(input logic [31:0] w, input logic [31:0] w2);
        exp_word = w | 32'h1;
        wr(`ADDR_CMD, w);
        wr(`ADDR_CMD, w2);
        v = 32'h1;
        for (int i = 0; i < 500 && v[0] === 1'b1; i++) rd(`ADDR_STAT, v);
        check(v[0], 1'b0);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Shifts in each bit clocked out while this module is selected.
    always @(posedge u_synth_link_if.ser_clk) begin
        if (sel == 3'h2) begin
            cap = {cap[30:0], u_synth_link_if.ser_data};
            nbits++;
        end
    end
    // Compares every latched frame with the first word of the load, control bit set.
    always @(posedge u_synth_link_if.ser_latch) begin
        frames++;
        check(sel, 3'h2);
        check(nbits, 32);
        check(cap, exp_word);
        nbits = 0;
    end
    // Cuts a hang short.
    initial begin
        #1000000;
        err_count++;
        conclude();
    end
    // Main sequence.
    initial begin
        repeat (8) @(posedge mclk_in);
        check(fault_lamp_out, 1'b1);
        resetn_in <= 1'b1;
        @(posedge mclk_in);
        rd(`ADDR_STAT, v);
        check(v, 32'h0);
        rd(4'hf, v);
        check(v, 32'h0);
        $display("test reset done");
        load(32'hffff_fffe, 32'h0);
        check(frames, 1);
        check(irq_out, 1'b0);
        rd(`ADDR_IRQ_STAT, v);
        check(v[0], 1'b1);
        wr(`ADDR_IRQ_CLR, 32'h1);
        wr(`ADDR_IRQ_EN, 32'h1);
        // Reference and main both divide by one, so both pulses coincide.
        load(32'h0004_0100, 32'h0020_0800);
        check(frames, 2);
        rd(`ADDR_IRQ_STAT, v);
        check(v[0], 1'b1);
        check(irq_out, 1'b1);
        wr(`ADDR_IRQ_CLR, 32'h1);
        check(irq_out, 1'b0);
        rd(`ADDR_IRQ_STAT, v);
        check(v[0], 1'b0);
        $display("test loads and interrupt done");
        fb_on <= 1'b0;
        repeat (300) @(posedge mclk_in);
        check({u_synth_link_if.lock_flag, fault_lamp_out}, 2'h1);
        rd(`ADDR_STAT, v);
        check(v, 32'h0);
        fb_on <= 1'b1;
        repeat (300) @(posedge mclk_in);
        check({u_synth_link_if.lock_flag, fault_lamp_out}, 2'h2);
        rd(`ADDR_STAT, v);
        check(v, 32'h2);
        $display("test lock done");
        for (int m = 0; m < 3; m++) begin
            mode <= m[1:0];
            wr(`ADDR_MODE, m);
            rd(`ADDR_MODE, v);
            check(v, m);
            repeat (8) @(posedge mclk_in);
            trip[m] = {open_loop_out, enable_not_out, tune_ctrl_out};
        end
        check(trip[0] != trip[1] && trip[1] != trip[2] && trip[0] != trip[2], 1'b1);
        $display("test modes done");
        conclude();
    end
endmodule
`default_nettype wire
